// ==== rtl/plm_lag_filter.sv ====
// first-order lag filter, time constant set as a power-of-two shift
module plm_lag_filter import plm_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic [3:0] shift,
	input wire logic signed [31:0] x,
	output logic signed [31:0] y
);
	// shift keeps it multiplier-free; the time constant is 2^shift cycles
	wire signed [32:0] diff = 33'(x) - 33'(y);
	wire signed [32:0] step = diff >>> shift;
	wire signed [31:0] next_y = y + step[31:0];
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			y <= 32'sh0000_0000;
		end else if (ce) begin
			y <= next_y;
		end
	end
endmodule : plm_lag_filter

// ==== rtl/plm_map.svh ====
// register map, field positions, reset values and limits of the position loop monitor
`ifndef PLM_MAP_SVH
`define PLM_MAP_SVH

// ****************************************
// register indices
// ****************************************
`define PLM_ADDR_CTRL 5'h00
`define PLM_ADDR_WIDTH 5'h01
`define PLM_ADDR_LEVEL 5'h02
`define PLM_ADDR_KP 5'h03
`define PLM_ADDR_FFGAIN 5'h04
`define PLM_ADDR_FFFILT 5'h05
`define PLM_ADDR_STATUS 5'h06
`define PLM_ADDR_DROOP 5'h07
`define PLM_ADDR_INT_STAT 5'h08
`define PLM_ADDR_INT_MASK 5'h09
`define PLM_ADDR_SPEED 5'h0A
`define PLM_ADDR_TERM_BASE 5'h10
`define PLM_ADDR_TERM_LAST 5'h16

// ****************************************
// field positions
// ****************************************
`define PLM_CTRL_PANEL 0
`define PLM_CTRL_CLEAR 1
`define PLM_STAT_INPOS 0
`define PLM_STAT_FAULT 1
`define PLM_STAT_DRIVE 2
`define PLM_INT_FAULT 0
`define PLM_INT_INPOS 1

// ****************************************
// reset values and limits
// ****************************************
`define PLM_WIDTH_RESET 32'h0000_0064
`define PLM_WIDTH_MAX 32'h0000_7FFF
`define PLM_LEVEL_RESET 32'h0000_0028
`define PLM_LEVEL_MAX 32'h0000_0190
`define PLM_LEVEL_OFF 32'h0000_270F
`define PLM_PANEL_MAX 32'h0000_270F
`define PLM_KP_RESET 32'h0000_0019
`define PLM_KP_MAX 32'h0000_0096
`define PLM_FFGAIN_RESET 32'h0000_0000
`define PLM_FFGAIN_MAX 32'h0000_0064
`define PLM_FFFILT_RESET 32'h0000_0000
`define PLM_FFFILT_MAX 32'h0000_000F
`define PLM_CODE_POS 8'h24
`define PLM_CODE_NEG 8'h88
`define PLM_CODE_RESET 8'h00
`define PLM_TERM_COUNT 7
`define PLM_FF_SHIFT 16
`define PLM_PCT_MUL 12'h51F
`define PLM_PCT_SHIFT 17

`endif

// ==== rtl/plm_pkg.sv ====
// types shared by the position loop monitor modules
package plm_pkg;
	typedef logic signed [31:0] plm_droop_t;
	typedef enum logic [0:0] {
		PLM_RUN = 1'b0,
		PLM_TRIPPED = 1'b1
	} plm_state_t;
endpackage : plm_pkg

// ==== rtl/plm_quad_decoder.sv ====
// encoder pin synchroniser and x4 quadrature decoder
module plm_quad_decoder import plm_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic enc_a,
	input wire logic enc_b,
	output logic fb_up,
	output logic fb_down
);
	// ****************************************
	// two-stage synchroniser
	// ****************************************
	logic [1:0] sync1;
	logic [1:0] sync2;
	logic [1:0] prev;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sync1 <= 2'h0;
			sync2 <= 2'h0;
			prev <= 2'h0;
		end else if (ce) begin
			sync1 <= {enc_a, enc_b};
			sync2 <= sync1;
			prev <= sync2;
		end
	end

	// ****************************************
	// decode; a double step is an illegal jump and is dropped
	// ****************************************
	wire [3:0] trans = {prev, sync2};
	wire next_up = (trans == 4'h2) || (trans == 4'hB) || (trans == 4'hD) || (trans == 4'h4);
	wire next_down = (trans == 4'h1) || (trans == 4'h7) || (trans == 4'hE) || (trans == 4'h8);
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			fb_up <= 1'b0;
			fb_down <= 1'b0;
		end else if (ce) begin
			fb_up <= next_up;
			fb_down <= next_down;
		end
	end
endmodule : plm_quad_decoder

// ==== rtl/plm_top.sv ====
// position loop monitor: deviation counter, in-position and fault checks, gain stage
//
// Our own choices: the strobed register port and the address map.
`include "plm_map.svh"

module plm_top import plm_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic cmd_pulse,
	input wire logic cmd_dir,
	input wire logic enc_a,
	input wire logic enc_b,
	input wire logic [4:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	output logic in_position_flag,
	output logic position_deviation_fault,
	output logic drive_enable,
	output logic signed [31:0] speed_cmd,
	output logic [6:0] out_terminal,
	output logic irq
);
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] panel_limit(input logic panel, input logic [31:0] v);
		panel_limit = (panel && (v > `PLM_PANEL_MAX)) ? `PLM_PANEL_MAX : v;
	endfunction : panel_limit

	function automatic logic wr_hit(input logic w, input logic [4:0] a, input logic [4:0] target);
		wr_hit = w && (a == target);
	endfunction : wr_hit

	// ****************************************
	// registers
	// ****************************************
	logic panel_mode;
	logic [31:0] in_position_width_setting;
	logic [31:0] excess_error_level_setting;
	logic [31:0] position_loop_gain_setting;
	logic [31:0] feed_forward_gain_setting;
	logic [31:0] feed_forward_filter_setting;
	logic [7:0] output_terminal_function_codes [0:6];
	logic [1:0] int_stat;
	logic [1:0] int_mask;
	plm_droop_t droop;
	plm_state_t state;

	// ****************************************
	// command pin synchroniser and edge detect
	// ****************************************
	logic cmd_s1;
	logic cmd_s2;
	logic cmd_s3;
	logic dir_s1;
	logic dir_s2;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cmd_s1 <= 1'b0;
			cmd_s2 <= 1'b0;
			cmd_s3 <= 1'b0;
			dir_s1 <= 1'b0;
			dir_s2 <= 1'b0;
		end else if (ce) begin
			cmd_s1 <= cmd_pulse;
			cmd_s2 <= cmd_s1;
			cmd_s3 <= cmd_s2;
			dir_s1 <= cmd_dir;
			dir_s2 <= dir_s1;
		end
	end
	wire cmd_edge = cmd_s2 && !cmd_s3;
	wire cmd_fwd = cmd_edge && !dir_s2;
	wire cmd_rev = cmd_edge && dir_s2;

	logic fb_up;
	logic fb_down;
	plm_quad_decoder u_quad (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.enc_a(enc_a),
		.enc_b(enc_b),
		.fb_up(fb_up),
		.fb_down(fb_down)
	);

	// ****************************************
	// write decode
	// ****************************************
	wire wr_ctrl = wr_hit(wr, addr, `PLM_ADDR_CTRL);
	wire wr_width = wr_hit(wr, addr, `PLM_ADDR_WIDTH);
	wire wr_level = wr_hit(wr, addr, `PLM_ADDR_LEVEL);
	wire wr_kp = wr_hit(wr, addr, `PLM_ADDR_KP);
	wire wr_ffgain = wr_hit(wr, addr, `PLM_ADDR_FFGAIN);
	wire wr_fffilt = wr_hit(wr, addr, `PLM_ADDR_FFFILT);
	wire wr_istat = wr_hit(wr, addr, `PLM_ADDR_INT_STAT);
	wire wr_imask = wr_hit(wr, addr, `PLM_ADDR_INT_MASK);
	wire clear_req = wr_ctrl && wdata[`PLM_CTRL_CLEAR];
	wire [31:0] width_val = panel_limit(panel_mode, wdata);
	wire [31:0] level_val = panel_limit(panel_mode, wdata);
	// writes out of range after the panel clamp are ignored, the old setting stays
	wire width_ok = width_val <= `PLM_WIDTH_MAX;
	wire level_ok = (level_val <= `PLM_LEVEL_MAX) || (level_val == `PLM_LEVEL_OFF);
	wire kp_ok = wdata <= `PLM_KP_MAX;
	wire ffgain_ok = wdata <= `PLM_FFGAIN_MAX;
	wire fffilt_ok = wdata <= `PLM_FFFILT_MAX;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			panel_mode <= 1'b0;
			in_position_width_setting <= `PLM_WIDTH_RESET;
			excess_error_level_setting <= `PLM_LEVEL_RESET;
			position_loop_gain_setting <= `PLM_KP_RESET;
			feed_forward_gain_setting <= `PLM_FFGAIN_RESET;
			feed_forward_filter_setting <= `PLM_FFFILT_RESET;
			int_mask <= 2'h0;
		end else if (ce) begin
			if (wr_ctrl) begin
				panel_mode <= wdata[`PLM_CTRL_PANEL];
			end
			if (wr_width && width_ok) begin
				in_position_width_setting <= width_val;
			end
			if (wr_level && level_ok) begin
				excess_error_level_setting <= level_val;
			end
			if (wr_kp && kp_ok) begin
				position_loop_gain_setting <= wdata;
			end
			if (wr_ffgain && ffgain_ok) begin
				feed_forward_gain_setting <= wdata;
			end
			if (wr_fffilt && fffilt_ok) begin
				feed_forward_filter_setting <= wdata;
			end
			if (wr_imask) begin
				int_mask <= wdata[1:0];
			end
		end
	end

	generate
		for (genvar t = 0; t < `PLM_TERM_COUNT; t++) begin : g_code
			wire wr_code = wr_hit(wr, addr, 5'(`PLM_ADDR_TERM_BASE + t));
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					output_terminal_function_codes[t] <= `PLM_CODE_RESET;
				end else if (ce && wr_code) begin
					output_terminal_function_codes[t] <= wdata[7:0];
				end
			end
		end
	endgenerate

	// ****************************************
	// deviation counter
	// ****************************************
	wire signed [1:0] cmd_step = cmd_fwd ? 2'sh1 : (cmd_rev ? -2'sh1 : 2'sh0);
	wire signed [1:0] fb_step = fb_up ? 2'sh1 : (fb_down ? -2'sh1 : 2'sh0);
	wire plm_droop_t next_droop = droop + 32'(cmd_step) - 32'(fb_step);
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			droop <= 32'sh0000_0000;
		end else if (ce) begin
			droop <= clear_req ? 32'sh0000_0000 : next_droop;
		end
	end
	wire [31:0] droop_abs = droop[31] ? 32'(-droop) : 32'(droop);

	// ****************************************
	// in-position and fault
	// ****************************************
	wire next_in_pos = droop_abs < in_position_width_setting;
	wire level_off = excess_error_level_setting == `PLM_LEVEL_OFF;
	wire over_level = !level_off && (droop_abs > excess_error_level_setting);
	// the trip beats a clear in the same cycle, so a live fault is never lost
	plm_state_t next_state;
	always_comb begin
		next_state = state;
		unique case (state)
			PLM_RUN: begin
				if (over_level) begin
					next_state = PLM_TRIPPED;
				end
			end
			PLM_TRIPPED: begin
				if (clear_req && !over_level) begin
					next_state = PLM_RUN;
				end
			end
		endcase
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state <= PLM_RUN;
			in_position_flag <= 1'b0;
			position_deviation_fault <= 1'b0;
			drive_enable <= 1'b0;
		end else if (ce) begin
			state <= next_state;
			in_position_flag <= next_in_pos;
			position_deviation_fault <= next_state == PLM_TRIPPED;
			drive_enable <= next_state == PLM_RUN;
		end
	end

	// ****************************************
	// output terminal routing
	// ****************************************
	logic [6:0] next_term;
	always_comb begin
		for (int t = 0; t < `PLM_TERM_COUNT; t++) begin
			next_term[t] = ((output_terminal_function_codes[t] == `PLM_CODE_POS) && next_in_pos) ||
				((output_terminal_function_codes[t] == `PLM_CODE_NEG) && !next_in_pos);
		end
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			out_terminal <= 7'h00;
		end else if (ce) begin
			out_terminal <= next_term;
		end
	end

	// ****************************************
	// gain stage: kp * droop + filtered feed-forward
	// ****************************************
	// command rate estimate: each pulse is a step of 2^16, smoothed by the lag
	wire signed [31:0] ff_in = 32'(cmd_step) <<< `PLM_FF_SHIFT;
	logic signed [31:0] ff_filt;
	plm_lag_filter u_ff (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.shift(feed_forward_filter_setting[3:0]),
		.x(ff_in),
		.y(ff_filt)
	);
	// percent scaling by 1311/2^17 avoids a divider; error about 0.02 %
	wire signed [63:0] ff_prod = 64'(ff_filt) * 64'(signed'({1'b0, feed_forward_gain_setting[6:0]})) *
		64'(signed'({1'b0, `PLM_PCT_MUL}));
	wire signed [63:0] ff_term = ff_prod >>> `PLM_PCT_SHIFT;
	wire signed [63:0] kp_term = 64'(droop) * 64'(signed'({1'b0, position_loop_gain_setting[7:0]}));
	wire signed [63:0] speed_sum = kp_term + ff_term;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			speed_cmd <= 32'sh0000_0000;
		end else if (ce) begin
			speed_cmd <= (next_state == PLM_TRIPPED) ? 32'sh0000_0000 : speed_sum[31:0];
		end
	end

	// ****************************************
	// interrupts
	// ****************************************
	logic in_pos_prev;
	wire [1:0] events = {next_in_pos && !in_pos_prev, over_level && (state == PLM_RUN)};
	wire [1:0] w1c = wr_istat ? wdata[1:0] : 2'h0;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			in_pos_prev <= 1'b0;
			int_stat <= 2'h0;
			irq <= 1'b0;
		end else if (ce) begin
			in_pos_prev <= next_in_pos;
			int_stat <= (int_stat & ~w1c) | events;
			irq <= |(((int_stat & ~w1c) | events) & int_mask);
		end
	end

	// ****************************************
	// read path
	// ****************************************
	wire [4:0] term_idx = addr - `PLM_ADDR_TERM_BASE;
	wire term_hit = (addr >= `PLM_ADDR_TERM_BASE) && (addr <= `PLM_ADDR_TERM_LAST);
	logic [31:0] next_rdata;
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (term_hit) begin
			next_rdata = {24'h00_0000, output_terminal_function_codes[term_idx[2:0]]};
		end else begin
			case (addr)
				`PLM_ADDR_CTRL: next_rdata = {31'h0000_0000, panel_mode};
				`PLM_ADDR_WIDTH: next_rdata = in_position_width_setting;
				`PLM_ADDR_LEVEL: next_rdata = excess_error_level_setting;
				`PLM_ADDR_KP: next_rdata = position_loop_gain_setting;
				`PLM_ADDR_FFGAIN: next_rdata = feed_forward_gain_setting;
				`PLM_ADDR_FFFILT: next_rdata = feed_forward_filter_setting;
				`PLM_ADDR_STATUS: next_rdata = {29'h0000_0000, drive_enable, position_deviation_fault,
					in_position_flag};
				`PLM_ADDR_DROOP: next_rdata = droop;
				`PLM_ADDR_INT_STAT: next_rdata = {30'h0000_0000, int_stat};
				`PLM_ADDR_INT_MASK: next_rdata = {30'h0000_0000, int_mask};
				`PLM_ADDR_SPEED: next_rdata = speed_cmd;
				default: next_rdata = 32'h0000_0000;
			endcase
		end
	end
	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdata <= 32'h0000_0000;
		end else if (ce) begin
			rdata <= rd ? next_rdata : 32'h0000_0000;
		end
	end
endmodule : plm_top

// ==== tb/plm_motor_model.sv ====
// command pulse source and quadrature encoder facing the position loop monitor
module plm_motor_model (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic cmd_req,
	input wire logic fb_req,
	input wire logic rev,
	output logic cmd_pulse,
	output logic cmd_dir,
	output logic enc_a,
	output logic enc_b,
	output logic busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cmd_cnt;
	logic [2:0] fb_cnt;
	logic [1:0] ph;
	logic dir;
	logic junk;
	// ****
	// pulse and step shaping
	// ****
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cmd_cnt <= 4'h0;
			fb_cnt <= 3'h0;
			ph <= 2'h0;
			dir <= 1'b0;
			junk <= 1'b0;
		end else begin
			junk <= !junk;
			if (cmd_cnt != 4'h0) cmd_cnt <= cmd_cnt - 4'h1;
			else if (cmd_req) begin
				cmd_cnt <= 4'h8;
				dir <= rev;
			end
			if (fb_cnt != 3'h0) fb_cnt <= fb_cnt - 3'h1;
			else if (fb_req) begin
				fb_cnt <= 3'h4;
				ph <= rev ? ph - 2'h1 : ph + 2'h1;
			end
		end
	end
	// each level held four clocks, one above what the pin filter needs
	assign cmd_pulse = cmd_cnt > 4'h4;
	// direction only valid around a pulse, scrambled otherwise
	assign cmd_dir = (cmd_cnt != 4'h0) ? dir : junk;
	assign enc_a = ph[1] ^ ph[0];
	assign enc_b = ph[1];
	assign busy = cmd_cnt != 4'h0 || fb_cnt != 3'h0;
endmodule : plm_motor_model

// ==== tb/plm_props.sv ====
// port assertions for the position loop monitor
`include "plm_map.svh"
module plm_props import plm_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [4:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	input wire logic in_position_flag,
	input wire logic position_deviation_fault,
	input wire logic drive_enable,
	input wire logic signed [31:0] speed_cmd,
	input wire logic [6:0] out_terminal
);
	timeunit 1ns;
	timeprecision 1ps;
	logic panel;
	logic lvl_off;
	logic clr_d;
	logic [7:0] code [0:6];
	logic [6:0] exp_term;
	wire clr_req = wr && addr == `PLM_ADDR_CTRL && wdata[`PLM_CTRL_CLEAR];
	wire term_wr = wr && addr >= `PLM_ADDR_TERM_BASE && addr <= `PLM_ADDR_TERM_LAST;
	// panel clamp comes before the range check, so a wide panel write lands on the sentinel
	wire [31:0] lvl_v = (panel && wdata > `PLM_PANEL_MAX) ? `PLM_PANEL_MAX : wdata;
	// ****
	// shadow of the settings seen on the bus
	// ****
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			panel <= 1'b0;
			lvl_off <= 1'b0;
			clr_d <= 1'b0;
			for (int i = 0; i < 7; i++) code[i] <= 8'h00;
		end else begin
			clr_d <= clr_req;
			if (wr && addr == `PLM_ADDR_CTRL) panel <= wdata[`PLM_CTRL_PANEL];
			if (wr && addr == `PLM_ADDR_LEVEL && (lvl_v <= `PLM_LEVEL_MAX || lvl_v == `PLM_LEVEL_OFF)) begin
				lvl_off <= lvl_v == `PLM_LEVEL_OFF;
			end
			if (term_wr) code[3'(addr - `PLM_ADDR_TERM_BASE)] <= wdata[7:0];
		end
	end
	always_comb begin
		for (int i = 0; i < 7; i++) begin
			exp_term[i] = (code[i] == `PLM_CODE_POS) ? in_position_flag :
				(code[i] == `PLM_CODE_NEG) && !in_position_flag;
		end
	end
	// ****
	// properties
	// ****
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence s_wide_panel_wr;
		panel && wr && addr == `PLM_ADDR_WIDTH && wdata > `PLM_PANEL_MAX;
	endsequence
	sequence s_width_rd;
		rd && addr == `PLM_ADDR_WIDTH;
	endsequence
	AST_FAULT_STOP: assert property (position_deviation_fault |-> !drive_enable && speed_cmd == 32'sh0)
		else $error("drive not stopped on fault");
	AST_FAULT_HOLD: assert property (position_deviation_fault && !clr_req && !clr_d |=> position_deviation_fault)
		else $error("fault dropped without clear");
	AST_RECOVER: assert property ($fell(position_deviation_fault) |-> drive_enable)
		else $error("drive not back after clear");
	AST_SENTINEL: assert property (lvl_off && $past(lvl_off) |-> !$rose(position_deviation_fault))
		else $error("fault raised with check disabled");
	AST_TERM: assert property (!$past(term_wr) |-> out_terminal == exp_term)
		else $error("terminal output wrong");
	AST_KP_RANGE: assert property (rd && addr == `PLM_ADDR_KP |=> rdata <= `PLM_KP_MAX)
		else $error("loop gain out of range");
	AST_LEVEL_RANGE: assert property (rd && addr == `PLM_ADDR_LEVEL |=>
		rdata <= `PLM_LEVEL_MAX || rdata == `PLM_LEVEL_OFF) else $error("fault level out of range");
	AST_FFGAIN_RANGE: assert property (rd && addr == `PLM_ADDR_FFGAIN |=> rdata <= `PLM_FFGAIN_MAX)
		else $error("feed forward gain out of range");
	AST_PANEL_CLAMP: assert property (s_wide_panel_wr ##1 s_width_rd |=> rdata == `PLM_PANEL_MAX)
		else $error("panel width not clamped");
endmodule : plm_props

bind plm_top plm_props i_plm_props (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
	.rdata(rdata), .in_position_flag(in_position_flag), .position_deviation_fault(position_deviation_fault),
	.drive_enable(drive_enable), .speed_cmd(speed_cmd), .out_terminal(out_terminal));

// ==== tb/tb.sv ====
// self-checking bench for the position loop monitor
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, rst, ce, cmd_pulse, cmd_dir, enc_a, enc_b, wr, rd, cmd_req, fb_req, rev, busy;
	logic in_position_flag, position_deviation_fault, drive_enable, irq;
	logic [4:0] addr;
	logic [31:0] wdata, rdata, seed, v;
	logic signed [31:0] speed_cmd;
	logic [6:0] out_terminal;
	int err_total, checked, exp_droop, kp, wid, hit;
	logic [4:0] ra [0:6] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h1F};
	logic [31:0] rv [0:6] = '{32'h64, 32'h28, 32'h19, 32'h0, 32'h0, 32'h5, 32'h0};
	logic [4:0] wa [0:5] = '{5'h03, 5'h03, 5'h02, 5'h02, 5'h04, 5'h05};
	logic [31:0] wd [0:5] = '{32'h97, 32'h96, 32'h191, 32'h270F, 32'h65, 32'h10};
	logic [31:0] wx [0:5] = '{32'h19, 32'h96, 32'h28, 32'h270F, 32'h0, 32'h0};
	plm_top i_plm_top (.clk_sys(clk_sys), .rst(rst), .ce(ce), .cmd_pulse(cmd_pulse), .cmd_dir(cmd_dir),
		.enc_a(enc_a), .enc_b(enc_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.in_position_flag(in_position_flag), .position_deviation_fault(position_deviation_fault),
		.drive_enable(drive_enable), .speed_cmd(speed_cmd), .out_terminal(out_terminal), .irq(irq));
	plm_motor_model i_plm_motor_model (.clk_sys(clk_sys), .rst(rst), .cmd_req(cmd_req), .fb_req(fb_req),
		.rev(rev), .cmd_pulse(cmd_pulse), .cmd_dir(cmd_dir), .enc_a(enc_a), .enc_b(enc_b), .busy(busy));
	always #20 clk_sys = !clk_sys;
	// ****
	// helpers
	// ****
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s exp %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_sim
	task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk_sys);
		wr <= 1'b0;
		// step off the edge so a following request never reassigns wr in this time step
		#1;
	endtask : wr_reg
	task automatic rd_reg(input logic [4:0] a, output logic [31:0] d);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : rd_reg
	// one command pulse or one encoder step; the wait covers sync plus update latency
	task automatic move(input logic is_cmd, input logic r);
		int n;
		n = 0;
		cmd_req <= is_cmd;
		fb_req <= !is_cmd;
		rev <= r;
		@(posedge clk_sys);
		cmd_req <= 1'b0;
		fb_req <= 1'b0;
		@(posedge clk_sys);
		while (busy && n < 40) begin
			@(posedge clk_sys);
			n++;
		end
		if (busy) begin
			err_total++;
			end_sim();
		end
		repeat (3) @(posedge clk_sys);
		#1;
		exp_droop += (is_cmd ^ r) ? 1 : -1;
	endtask : move
	task automatic look();
		logic ip;
		ip = exp_droop < wid && -exp_droop < wid;
		rd_reg(5'h07, v);
		chk("droop", v, exp_droop);
		chk("inpos", in_position_flag, ip);
		chk("speed", speed_cmd, kp * exp_droop);
		chk("term", out_terminal, {5'h00, !ip, ip});
	endtask : look
	// ****
	// main sequence
	// ****
	initial begin
		{clk_sys, ce, wr, rd, cmd_req, fb_req, rev, addr, wdata} = '0;
		rst = 1'b1;
		ce = 1'b1;
		seed = 32'h9287;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		for (int i = 0; i < 7; i++) begin
			rd_reg(ra[i], v);
			chk("reset", v, rv[i]);
		end
		chk("drive", drive_enable, 1);
		$display("done reset values");
		for (int i = 0; i < 6; i++) begin
			wr_reg(wa[i], wd[i]);
			rd_reg(wa[i], v);
			chk("limit", v, wx[i]);
		end
		seed = lfsr(seed);
		kp = 5 + seed % 46;
		wr_reg(5'h03, kp);
		wr_reg(5'h10, 32'h24);
		wr_reg(5'h11, 32'h88);
		wr_reg(5'h12, {27'h0, seed[4:0]});
		wid = 3;
		wr_reg(5'h01, wid);
		$display("done settings");
		for (int i = 0; i < 24; i++) begin
			seed = lfsr(seed);
			move(seed[0], seed[1]);
			look();
			chk("nofault", position_deviation_fault, 0);
		end
		while (exp_droop != 0) move(1'b0, exp_droop < 0);
		$display("done random walk");
		wr_reg(5'h02, 32'h4);
		wr_reg(5'h09, 32'h1);
		for (int i = 1; i <= 5; i++) begin
			move(1'b1, 1'b0);
			if (i < 5) look();
			chk("fault", position_deviation_fault, i == 5);
		end
		chk("stop_drive", drive_enable, 0);
		chk("stop_speed", speed_cmd, 0);
		chk("stop_irq", irq, 1);
		wr_reg(5'h08, 32'h1);
		rd_reg(5'h06, v);
		chk("tripped", v, 32'h2);
		chk("tripped_irq", irq, 0);
		// first clear zeroes droop but the live trip wins; the second one releases the drive
		wr_reg(5'h00, 32'h2);
		wr_reg(5'h00, 32'h2);
		exp_droop = 0;
		repeat (2) @(posedge clk_sys);
		rd_reg(5'h06, v);
		chk("rerun", v, 32'h5);
		$display("done fault trip");
		wr_reg(5'h00, 32'h1);
		wr_reg(5'h01, 32'h2EE0);
		rd_reg(5'h01, v);
		chk("panel", v, 32'h270F);
		wr_reg(5'h00, 32'h0);
		wr_reg(5'h01, 32'h2EE0);
		rd_reg(5'h01, v);
		chk("full", v, 32'h2EE0);
		$display("done panel limit");
		wr_reg(5'h04, 32'h64);
		wr_reg(5'h05, 32'h1);
		cmd_req <= 1'b1;
		@(posedge clk_sys);
		cmd_req <= 1'b0;
		hit = 0;
		repeat (30) @(negedge clk_sys) if (speed_cmd > kp * (exp_droop + 1)) hit++;
		exp_droop++;
		chk("ff", hit > 2, 1);
		repeat (300) @(posedge clk_sys);
		#1;
		chk("ffdecay", speed_cmd, kp * exp_droop);
		$display("done feed forward");
		end_sim();
	end
endmodule : tb
